// *** src/cmac_pkg.sv ***
// Notes on behaviour
// - Start sending only after the medium is idle; defer while carrier is present.
// - Watch the collision input while sending and treat it as a collision.
// - After a collision wait a random truncated binary exponential backoff delay.
// - Every retransmission restarts from the first byte of the frame.
// - A frame opens with an 8-byte preamble and closes with a 4-byte check.
// - Destination, source, byte count and data follow the preamble in order.
// - The data field holds 46 to 1500 bytes and passes through unchanged.
// - Short frames are padded to 64 bytes; received pad bytes stay in the frame.
// - Line bits are Manchester coded, rising mid-bit for one, falling for zero.
// - Bits of each byte go and come least significant first.
// - Addresses are six bytes; the first line bit marks broadcast or multicast.
// - The receive filter holds six independent station addresses.
// - The check sequence is judged only once the whole frame has arrived.
// - A collision sends an 8-byte jam, or two bytes with short slot.
// - Keep a 9.6 us gap between frames, or 2.4 us with short slot.
package cmac_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CMAC_CLK_NS = 10;
   localparam int CMAC_BIT_NS = 100;
   localparam int CMAC_BIT_CYC = CMAC_BIT_NS / CMAC_CLK_NS;
   localparam int CMAC_HALF_CYC = CMAC_BIT_CYC / 2;
   localparam int CMAC_MID_MIN = CMAC_BIT_CYC - 3;
   localparam int CMAC_IFG_NS = 9600;
   localparam int CMAC_IFG_SHORT_NS = 2400;
   localparam int CMAC_SLOT_NS = 51200;
   localparam int CMAC_SLOT_SHORT_NS = 12000;
   localparam int CMAC_IFG_CYC = (CMAC_IFG_NS + CMAC_CLK_NS - 1) / CMAC_CLK_NS;
   localparam int CMAC_IFG_SHORT_CYC =
      (CMAC_IFG_SHORT_NS + CMAC_CLK_NS - 1) / CMAC_CLK_NS;
   localparam int CMAC_SLOT_CYC = (CMAC_SLOT_NS + CMAC_CLK_NS - 1) / CMAC_CLK_NS;
   localparam int CMAC_SLOT_SHORT_CYC =
      (CMAC_SLOT_SHORT_NS + CMAC_CLK_NS - 1) / CMAC_CLK_NS;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int CMAC_PRE_BYTES = 8;
   localparam int CMAC_FCS_BYTES = 4;
   localparam int CMAC_JAM_BYTES = 8;
   localparam int CMAC_JAM_SHORT_BYTES = 2;
   localparam int CMAC_MIN_FRAME = 64;
   localparam int CMAC_MIN_BODY = CMAC_MIN_FRAME - CMAC_FCS_BYTES;
   localparam int CMAC_MAX_BODY = 1514;
   localparam int CMAC_ADDR_BYTES = 6;
   localparam int CMAC_NUM_STATIONS = 6;
   localparam int CMAC_ATTEMPT_MAX = 16;
   localparam int CMAC_BACKOFF_CEIL = 10;
   localparam logic [7:0] CMAC_PRE_BYTE = 8'h55;
   localparam logic [7:0] CMAC_SFD_BYTE = 8'hd5;
   localparam logic [7:0] CMAC_JAM_BYTE = 8'h55;
   localparam logic [7:0] CMAC_PAD_BYTE = 8'h00;
   localparam logic [31:0] CMAC_CRC_POLY = 32'hedb88320;
   localparam logic [31:0] CMAC_CRC_INIT = 32'hffffffff;
   localparam logic [31:0] CMAC_CRC_RESIDUE = 32'hdebb20e3;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic last;
      logic [7:0] data;
   } cmac_txw_t;

   typedef struct packed {
      logic done;
      logic fcs_err;
      logic short_err;
   } cmac_rxst_t;

   typedef enum logic [2:0] {
      T_IDLE = 3'b000, T_DEFER = 3'b001, T_PRE = 3'b010, T_BODY = 3'b011,
      T_FCS = 3'b100, T_JAM = 3'b101, T_BACKOFF = 3'b110
   } cmac_tst_t;

   typedef enum logic [1:0] {
      R_IDLE = 2'b00, R_HUNT = 2'b01, R_DATA = 2'b10
   } cmac_rst_t;

   // Reflected serial update of the frame check register by one bit.
   function automatic logic [31:0] cmac_crc_bit(logic [31:0] c, logic b);
      cmac_crc_bit = (c >> 1) ^ ((c[0] ^ b) ? CMAC_CRC_POLY : 32'h00000000);
   endfunction

endpackage

// *** src/cmac_mac.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Small FIFO with registered flags
// ----------------------------------------------------------------
module cmac_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Filling side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Draining side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic next_in_ready, next_out_valid, push, pop;

   // Flags are computed from the next count so both come from flops.
   always_comb begin
      push = in_valid & in_ready;
      pop = out_valid & out_ready;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      if (push) begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      next_in_ready = (next_count != (AW+1)'(DEPTH));
      next_out_valid = (next_count != '0);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count <= '0;
         wr_ptr <= '0;
         rd_ptr <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         count <= next_count;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         in_ready <= next_in_ready;
         out_valid <= next_out_valid;
      end
   end

   // Storage needs no reset; the valid flag guards stale words.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   assign out_data = mem[rd_ptr];
endmodule // cmac_fifo

// ----------------------------------------------------------------
// Media access, framing and line coding
// ----------------------------------------------------------------
module cmac_mac
   import cmac_pkg::*;
#(
   parameter int SLOT_CYC = CMAC_SLOT_CYC,
   parameter int FIFO_DEPTH = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Host transmit stream
   input wire logic tx_valid,
   input wire cmac_txw_t tx_word,
   output logic tx_ready,
   output logic tx_done,
   output logic tx_abort,
   // Host receive stream
   output logic rx_valid,
   output logic [7:0] rx_data,
   output cmac_rxst_t rx_status,
   output logic [47:0] rx_dest,
   // Configuration
   input wire logic short_slot,
   input wire logic [CMAC_NUM_STATIONS-1:0][47:0] station_addr,
   input wire logic [CMAC_NUM_STATIONS-1:0] station_en,
   // Transceiver
   output logic line_tx,
   output logic line_tx_en,
   input wire logic line_rx,
   input wire logic line_crs,
   input wire logic line_col
);
   // ----------------------------------------------------------------
   // Transmit FIFO and frame store
   // ----------------------------------------------------------------
   logic fq_valid, fq_ready;
   cmac_txw_t fq_word;
   logic [7:0] tmem [CMAC_MAX_BODY];
   logic [10:0] wlen, next_wlen, flen, next_flen, body_len;
   logic frame_rdy, next_frame_rdy, wr_en;

   cmac_fifo #(.WIDTH($bits(cmac_txw_t)), .DEPTH(FIFO_DEPTH)) u_txq (
      .clk(clk),
      .rst(rst),
      .in_valid(tx_valid),
      .in_data(tx_word),
      .in_ready(tx_ready),
      .out_valid(fq_valid),
      .out_data(fq_word),
      .out_ready(fq_ready)
   );

   // The whole frame is kept so a retry can replay it; the FIFO stalls
   // the host while a stored frame waits or is on the wire.
   assign fq_ready = ~frame_rdy;
   assign wr_en = fq_valid & fq_ready;
   assign body_len = (flen < 11'(CMAC_MIN_BODY)) ? 11'(CMAC_MIN_BODY) : flen;

   always_ff @(posedge clk) begin
      if (wr_en) begin
         tmem[wlen] <= fq_word.data;
      end
   end

   // ----------------------------------------------------------------
   // Transmit state machine
   // ----------------------------------------------------------------
   cmac_tst_t tst, next_tst;
   logic [7:0] tbyte, next_tbyte;
   logic [2:0] tbit, next_tbit;
   logic [3:0] ttick, next_ttick;
   logic [10:0] tidx, next_tidx;
   logic [31:0] tcrc, next_tcrc;
   logic [4:0] tries, next_tries;
   logic [15:0] timer, next_timer, lfsr, next_lfsr;
   logic [9:0] slots, next_slots, bmask;
   logic [3:0] bexp;
   logic next_line_tx, next_line_tx_en, next_tx_done, next_tx_abort;
   logic sending, bit_end, cur_bit;
   logic [15:0] ifg_cyc, slot_len;
   logic [10:0] jam_len;

   always_comb begin
      ifg_cyc = short_slot ? 16'(CMAC_IFG_SHORT_CYC) : 16'(CMAC_IFG_CYC);
      slot_len = short_slot ? 16'(CMAC_SLOT_SHORT_CYC) : 16'(SLOT_CYC);
      jam_len = short_slot ? 11'(CMAC_JAM_SHORT_BYTES) : 11'(CMAC_JAM_BYTES);
      sending = (tst == T_PRE) || (tst == T_BODY) || (tst == T_FCS)
         || (tst == T_JAM);
      cur_bit = tbyte[tbit];
      bit_end = (ttick == 4'(CMAC_BIT_CYC - 1));
      bexp = (tries + 5'd1 > 5'(CMAC_BACKOFF_CEIL)) ?
         4'(CMAC_BACKOFF_CEIL) : 4'(tries + 5'd1);
      bmask = ~(10'h3ff << bexp);
      next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      next_tst = tst;
      next_tbyte = tbyte;
      next_tbit = tbit;
      next_ttick = ttick;
      next_tidx = tidx;
      next_tcrc = tcrc;
      next_tries = tries;
      next_timer = timer;
      next_slots = slots;
      next_wlen = wlen;
      next_flen = flen;
      next_frame_rdy = frame_rdy;
      next_tx_done = 1'b0;
      next_tx_abort = 1'b0;
      // First half carries the inverse, so one rises mid-bit.
      next_line_tx = sending ? ((ttick < 4'(CMAC_HALF_CYC)) ? ~cur_bit
         : cur_bit) : 1'b0;
      next_line_tx_en = sending;
      // Store host bytes until the last one arrives.
      if (wr_en) begin
         if (fq_word.last || wlen == 11'(CMAC_MAX_BODY - 1)) begin
            next_frame_rdy = 1'b1;
            next_flen = wlen + 11'd1;
            next_wlen = '0;
         end else begin
            next_wlen = wlen + 11'd1;
         end
      end
      if (sending) begin
         next_ttick = bit_end ? 4'd0 : ttick + 4'd1;
         if (bit_end) begin
            next_tbit = tbit + 3'd1;
            if (tst == T_BODY) begin
               next_tcrc = cmac_crc_bit(tcrc, cur_bit);
            end
         end
      end
      case (tst)
         T_IDLE: begin
            next_timer = '0;
            if (frame_rdy) begin
               next_tst = T_DEFER;
            end
         end
         T_DEFER: begin
            // The gap restarts whenever another carrier appears.
            next_timer = line_crs ? 16'd0 : timer + 16'd1;
            if (!line_crs && timer == ifg_cyc - 16'd1) begin
               next_tst = T_PRE;
               next_tbyte = CMAC_PRE_BYTE;
               next_tbit = '0;
               next_ttick = '0;
               next_tidx = '0;
               next_tcrc = CMAC_CRC_INIT;
               next_line_tx_en = 1'b1;
            end
         end
         T_PRE, T_BODY, T_FCS: begin
            if (line_col && bit_end) begin
               next_tst = T_JAM;
               next_tbyte = CMAC_JAM_BYTE;
               next_tbit = '0;
               next_ttick = '0;
               next_tidx = '0;
            end else if (bit_end && tbit == 3'd7) begin
               next_tidx = tidx + 11'd1;
               if (tst == T_PRE) begin
                  if (tidx == 11'(CMAC_PRE_BYTES - 2)) begin
                     next_tbyte = CMAC_SFD_BYTE;
                  end else if (tidx == 11'(CMAC_PRE_BYTES - 1)) begin
                     next_tst = T_BODY;
                     next_tidx = '0;
                     next_tbyte = tmem[0];
                  end
               end else if (tst == T_BODY) begin
                  if (tidx + 11'd1 == body_len) begin
                     next_tst = T_FCS;
                     next_tidx = '0;
                     next_tbyte = ~next_tcrc[7:0];
                  end else if (tidx + 11'd1 < flen) begin
                     next_tbyte = tmem[tidx + 11'd1];
                  end else begin
                     next_tbyte = CMAC_PAD_BYTE;
                  end
               end else if (tidx == 11'(CMAC_FCS_BYTES - 1)) begin
                  next_tst = T_IDLE;
                  next_line_tx_en = 1'b0;
                  next_tx_done = 1'b1;
                  next_frame_rdy = 1'b0;
                  next_tries = '0;
               end else begin
                  next_tbyte = ~tcrc[8 * (tidx[1:0] + 2'd1) +: 8];
               end
            end
         end
         T_JAM: begin
            if (bit_end && tbit == 3'd7) begin
               next_tidx = tidx + 11'd1;
               if (tidx == jam_len - 11'd1) begin
                  next_line_tx_en = 1'b0;
                  next_timer = '0;
                  if (tries == 5'(CMAC_ATTEMPT_MAX - 1)) begin
                     next_tst = T_IDLE;
                     next_tx_abort = 1'b1;
                     next_frame_rdy = 1'b0;
                     next_tries = '0;
                  end else begin
                     next_tst = T_BACKOFF;
                     next_tries = tries + 5'd1;
                     next_slots = lfsr[9:0] & bmask;
                  end
               end
            end
         end
         T_BACKOFF: begin
            if (slots == '0) begin
               next_tst = T_DEFER;
               next_timer = '0;
            end else if (timer == slot_len - 16'd1) begin
               next_timer = '0;
               next_slots = slots - 10'd1;
            end else begin
               next_timer = timer + 16'd1;
            end
         end
         default: next_tst = T_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tst <= T_IDLE;
         tbyte <= '0;
         tbit <= '0;
         ttick <= '0;
         tidx <= '0;
         tcrc <= CMAC_CRC_INIT;
         tries <= '0;
         timer <= '0;
         slots <= '0;
         lfsr <= 16'hace1;
         wlen <= '0;
         flen <= '0;
         frame_rdy <= 1'b0;
         line_tx <= 1'b0;
         line_tx_en <= 1'b0;
         tx_done <= 1'b0;
         tx_abort <= 1'b0;
      end else begin
         tst <= next_tst;
         tbyte <= next_tbyte;
         tbit <= next_tbit;
         ttick <= next_ttick;
         tidx <= next_tidx;
         tcrc <= next_tcrc;
         tries <= next_tries;
         timer <= next_timer;
         slots <= next_slots;
         lfsr <= next_lfsr;
         wlen <= next_wlen;
         flen <= next_flen;
         frame_rdy <= next_frame_rdy;
         line_tx <= next_line_tx;
         line_tx_en <= next_line_tx_en;
         tx_done <= next_tx_done;
         tx_abort <= next_tx_abort;
      end
   end

   // ----------------------------------------------------------------
   // Receive decoder, filter and check
   // ----------------------------------------------------------------
   cmac_rst_t rst_q, next_rst_q;
   logic rprev, rlast, next_rlast, rdrop, next_rdrop, rbit_stb;
   logic [3:0] rgap, next_rgap;
   logic [7:0] rsh, next_rsh, rbyte;
   logic [2:0] rbits, next_rbits;
   logic [10:0] ridx, next_ridx;
   logic [31:0] rcrc, next_rcrc;
   logic [47:0] next_rx_dest, cand;
   logic [CMAC_NUM_STATIONS-1:0] hits;
   logic next_rx_valid;
   logic [7:0] next_rx_data;
   cmac_rxst_t next_rx_status;

   // One comparator per station address.
   assign cand = {rbyte, rx_dest[39:0]};
   for (genvar i = 0; i < CMAC_NUM_STATIONS; i++) begin : g_stn
      assign hits[i] = station_en[i] && (station_addr[i] == cand);
   end

   // A mid-bit edge comes at least most of a bit after the last one;
   // edges sooner than that are cell boundaries and are skipped.
   always_comb begin
      rbit_stb = (line_rx != rprev) && (rgap >= 4'(CMAC_MID_MIN));
      next_rgap = rbit_stb ? 4'd0 : ((rgap == 4'hf) ? rgap : rgap + 4'd1);
      rbyte = {line_rx, rsh[7:1]};
      next_rst_q = rst_q;
      next_rlast = rlast;
      next_rdrop = rdrop;
      next_rsh = rsh;
      next_rbits = rbits;
      next_ridx = ridx;
      next_rcrc = rcrc;
      next_rx_dest = rx_dest;
      next_rx_valid = 1'b0;
      next_rx_data = rx_data;
      next_rx_status = '0;
      case (rst_q)
         R_IDLE: begin
            next_rgap = 4'hf;
            next_rlast = 1'b0;
            if (line_crs) begin
               next_rst_q = R_HUNT;
            end
         end
         R_HUNT: begin
            if (!line_crs) begin
               next_rst_q = R_IDLE;
            end else if (rbit_stb) begin
               next_rlast = line_rx;
               if (rlast && line_rx) begin
                  next_rst_q = R_DATA;
                  next_rbits = '0;
                  next_ridx = '0;
                  next_rdrop = 1'b0;
                  next_rcrc = CMAC_CRC_INIT;
               end
            end
         end
         R_DATA: begin
            if (!line_crs) begin
               // Judged only now, after the last byte is in.
               next_rst_q = R_IDLE;
               next_rx_status.done = ~rdrop && ridx >= 11'(CMAC_ADDR_BYTES);
               next_rx_status.fcs_err = (rcrc != CMAC_CRC_RESIDUE);
               next_rx_status.short_err = (ridx < 11'(CMAC_MIN_FRAME));
            end else if (rbit_stb) begin
               next_rsh = rbyte;
               next_rbits = rbits + 3'd1;
               next_rcrc = cmac_crc_bit(rcrc, line_rx);
               if (rbits == 3'd7) begin
                  next_ridx = (ridx == 11'h7ff) ? ridx : ridx + 11'd1;
                  if (ridx < 11'(CMAC_ADDR_BYTES)) begin
                     next_rx_dest[8 * ridx[2:0] +: 8] = rbyte;
                     if (ridx == 11'(CMAC_ADDR_BYTES - 1)) begin
                        next_rdrop = ~(|hits) && ~cand[0];
                     end
                  end else if (!rdrop) begin
                     next_rx_valid = 1'b1;
                     next_rx_data = rbyte;
                  end
               end
            end
         end
         default: next_rst_q = R_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rst_q <= R_IDLE;
         rprev <= 1'b0;
         rgap <= 4'hf;
         rlast <= 1'b0;
         rdrop <= 1'b0;
         rsh <= '0;
         rbits <= '0;
         ridx <= '0;
         rcrc <= CMAC_CRC_INIT;
         rx_dest <= '0;
         rx_valid <= 1'b0;
         rx_data <= '0;
         rx_status <= '0;
      end else begin
         rst_q <= next_rst_q;
         rprev <= line_rx;
         rgap <= next_rgap;
         rlast <= next_rlast;
         rdrop <= next_rdrop;
         rsh <= next_rsh;
         rbits <= next_rbits;
         ridx <= next_ridx;
         rcrc <= next_rcrc;
         rx_dest <= next_rx_dest;
         rx_valid <= next_rx_valid;
         rx_data <= next_rx_data;
         rx_status <= next_rx_status;
      end
   end
endmodule // cmac_mac

// *** testbench/cmac_xcvr.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Coax transceiver model
// ----------------------------------------
module cmac_xcvr (
   // Clock
   input wire logic clk,
   // Remote station activity
   input wire logic carrier_on,
   // MAC side
   input wire logic line_tx,
   input wire logic line_tx_en,
   output logic line_rx,
   output logic line_crs,
   output logic line_col
);
   logic rem_bit = 1'b0;

   // Own signal echoes back; a remote one on top of it is a collision.
   assign line_crs = line_tx_en | carrier_on;
   assign line_col = line_tx_en & carrier_on;
   assign line_rx = line_tx_en ? line_tx : rem_bit;

   // An idle cable holds no data; the line wanders to expose stale use.
   always @(posedge clk) if (!carrier_on) rem_bit <= ~rem_bit;

   // One Manchester cell per bit, first half inverted, low bit first.
   task automatic send_byte(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         repeat (5) @(posedge clk) rem_bit <= ~b[i];
         repeat (5) @(posedge clk) rem_bit <= b[i];
      end
   endtask
endmodule // cmac_xcvr

// *** testbench/cmac_chk.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module cmac_chk
   import cmac_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Host side
   input wire logic tx_done,
   input wire logic rx_valid,
   input wire cmac_rxst_t rx_status,
   input wire logic short_slot,
   // Line side
   input wire logic line_tx,
   input wire logic line_tx_en,
   input wire logic line_crs,
   input wire logic line_col
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [3:0] run;
   logic [9:0] gap;

   // Level run and idle time; both saturate so they never wrap.
   always_ff @(posedge clk) begin
      if (rst || !line_tx_en || line_tx != $past(line_tx))
         run <= 4'h1;
      else if (run != 4'hf)
         run <= run + 4'h1;
      if (rst || line_tx_en)
         gap <= 10'h000;
      else if (gap != 10'h3ff)
         gap <= gap + 10'h001;
   end

   property p_defer; $rose(line_tx_en) |-> !$past(line_crs, 2); endproperty
   a_defer: assert property (p_defer) else $error("sent on busy medium");
   property p_manch; line_tx_en |-> run <= 4'ha; endproperty
   a_manch: assert property (p_manch) else $error("no mid-bit edge");
   property p_gap;
      $rose(line_tx_en) |-> gap >= (short_slot ? 10'd240 : 10'd960);
   endproperty
   a_gap: assert property (p_gap) else $error("frame gap too short");
   property p_jam; line_tx_en && line_col |-> ##[1:700] !line_tx_en; endproperty
   a_jam: assert property (p_jam) else $error("jam too long");
   property p_stat;
      |rx_status |-> $past(line_crs, 2) && !$past(line_crs);
   endproperty
   a_stat: assert property (p_stat) else $error("early status");
   property p_rxv; rx_valid |-> $past(line_crs); endproperty
   a_rxv: assert property (p_rxv) else $error("byte with no carrier");
   property p_done; tx_done |-> $fell(line_tx_en); endproperty
   a_done: assert property (p_done) else $error("done not at end");
   property p_pulse; tx_done |=> !tx_done; endproperty
   a_pulse: assert property (p_pulse) else $error("done too long");

   c_done: cover property (tx_done);
   c_col: cover property (line_tx_en && line_col);
   c_rx: cover property (rx_status.done);
   c_fcs: cover property (rx_status.fcs_err);
endmodule // cmac_chk

bind cmac_mac cmac_chk u_chk (.*);

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import cmac_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic tx_valid = 1'b0;
   cmac_txw_t tx_word = '0;
   logic tx_ready, tx_done, tx_abort, rx_valid;
   logic [7:0] rx_data;
   cmac_rxst_t rx_status, st;
   logic [47:0] rx_dest;
   logic short_slot = 1'b0;
   logic [CMAC_NUM_STATIONS-1:0][47:0] station_addr;
   logic [CMAC_NUM_STATIONS-1:0] station_en = 6'h3f;
   logic line_tx, line_tx_en, line_rx, line_crs, line_col;
   logic carrier_on = 1'b0;
   logic en_d = 1'b0;
   logic [7:0] sh;
   logic [7:0] fr [0:63];
   logic [7:0] txq [$];
   logic [7:0] rxq [$];
   int mismatches = 0, checks_done = 0, ph = 0, nb = 0;

   always #5 clk = ~clk;

   cmac_mac #(.SLOT_CYC(50), .FIFO_DEPTH(4)) DUT (
      .clk(clk), .rst(rst), .tx_valid(tx_valid), .tx_word(tx_word),
      .tx_ready(tx_ready), .tx_done(tx_done), .tx_abort(tx_abort),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_status(rx_status),
      .rx_dest(rx_dest), .short_slot(short_slot),
      .station_addr(station_addr), .station_en(station_en),
      .line_tx(line_tx), .line_tx_en(line_tx_en), .line_rx(line_rx),
      .line_crs(line_crs), .line_col(line_col));

   cmac_xcvr XCVR (.clk(clk), .carrier_on(carrier_on), .line_tx(line_tx),
      .line_tx_en(line_tx_en), .line_rx(line_rx), .line_crs(line_crs),
      .line_col(line_col));

   // Decode line bytes late in each cell; each new attempt starts afresh.
   always @(posedge clk) begin
      ph = (line_tx_en && en_d) ? (ph + 1) % 10 : 0;
      if (line_tx_en && !en_d) txq.delete();
      if (line_tx_en && !en_d) nb = 0;
      en_d = line_tx_en;
      if (line_tx_en && ph == 7) begin
         sh = {line_tx, sh[7:1]};
         nb++;
         if (nb % 8 == 0) txq.push_back(sh);
      end
      if (rx_valid) rxq.push_back(rx_data);
      if (|rx_status) st = rx_status;
   end

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic wait_for(ref logic s, input logic v, input int lim,
                           output int n);
      n = 0;
      while (s !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk(n < lim, 1'b1);
   endtask

   // Header then data, byte values spread out.
   task automatic mk(input logic [47:0] d, input int len);
      for (int i = 0; i < 64; i++)
         fr[i] = (i < 6) ? d[8*i +: 8] : (i < 12) ? 8'(8'ha0 + i) :
                 (i == 13) ? 8'(len - 14) : (i == 12) ? 8'h00 : 8'(i * 37);
   endtask

   function automatic logic [7:0] ex(input int i, input int len);
      return (i < len) ? fr[i] : CMAC_PAD_BYTE;
   endfunction

   function automatic logic [31:0] fcs(input int len);
      logic [31:0] c;
      logic [7:0] b;
      c = CMAC_CRC_INIT;
      for (int i = 0; i < 60; i++) begin
         b = ex(i, len);
         for (int k = 0; k < 8; k++)
            c = (c >> 1) ^ ((c[0] ^ b[k]) ? CMAC_CRC_POLY : 32'h0);
      end
      return ~c;
   endfunction

   // Valid stays up across bytes so it is never driven twice in a step.
   task automatic send_frame(input int len);
      int n;
      for (int i = 0; i < len; i++) begin
         tx_valid <= 1'b1;
         tx_word <= '{last: (i == len - 1), data: fr[i]};
         n = 0;
         do @(posedge clk); while (tx_ready !== 1'b1 && n++ < 5000);
      end
      tx_valid <= 1'b0;
   endtask

   task automatic check_tx(input int len);
      logic [31:0] f;
      f = fcs(len);
      chk(txq.size(), 72);
      for (int i = 0; i < 8; i++)
         chk(txq[i], i < 7 ? CMAC_PRE_BYTE : CMAC_SFD_BYTE);
      for (int i = 0; i < 60; i++)
         chk(txq[8 + i], ex(i, len));
      for (int i = 0; i < 4; i++)
         chk(txq[68 + i], f[8*i +: 8]);
   endtask

   task automatic t_defer_pad();
      int n;
      mk(48'h10, 16);
      carrier_on <= 1'b1;
      send_frame(16);
      repeat (1200) @(posedge clk);
      chk(line_tx_en, 1'b0);
      carrier_on <= 1'b0;
      wait_for(tx_done, 1'b1, 8000, n);
      check_tx(16);
   endtask

   task automatic t_collide(input logic ss);
      int n, j, jam;
      jam = ss ? 160 : 640;
      short_slot <= ss;
      mk(48'h10, 60);
      send_frame(60);
      wait_for(line_tx_en, 1'b1, 3000, n);
      repeat (100) @(posedge clk);
      carrier_on <= 1'b1;
      wait_for(line_tx_en, 1'b0, 1000, j);
      chk(j >= jam && j <= jam + 20, 1'b1);
      carrier_on <= 1'b0;
      wait_for(tx_done, 1'b1, 12000, n);
      check_tx(60);
   endtask

   task automatic t_rx(input logic [47:0] d, input logic bad, input logic acc);
      logic [31:0] f;
      mk(d, 60);
      f = fcs(60) ^ 32'(bad);
      rxq.delete();
      st = '0;
      carrier_on <= 1'b1;
      for (int i = 0; i < 8; i++)
         XCVR.send_byte(i < 7 ? CMAC_PRE_BYTE : CMAC_SFD_BYTE);
      for (int i = 0; i < 64; i++)
         XCVR.send_byte(i < 60 ? fr[i] : f[8*(i-60) +: 8]);
      carrier_on <= 1'b0;
      repeat (5) @(posedge clk);
      chk(rx_dest, d);
      chk(rxq.size(), acc ? 58 : 0);
      for (int i = 0; i < 54 && acc; i++)
         chk(rxq[i], fr[6 + i]);
      chk(st, {acc, bad, 1'b0});
   endtask

   initial begin
      for (int i = 0; i < CMAC_NUM_STATIONS; i++)
         station_addr[i] = {32'h0, 8'(i), 8'h10};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_defer_pad();
      t_collide(1'b0);
      t_collide(1'b1);
      t_rx(station_addr[5], 1'b0, 1'b1);
      t_rx(station_addr[0], 1'b1, 1'b1);
      t_rx(48'h0000000ff12, 1'b0, 1'b0);
      t_rx('1, 1'b0, 1'b1);
      end_of_test();
   end

   // A hang ends the run as a failure.
   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      end_of_test();
   end
endmodule // tb_top
